// file: io_pin_pkg.sv
// constants, types and register map for the pin default and configuration block
package io_pin_pkg;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned CFG_HALF_NS   = 500;
  localparam int unsigned CFG_HALF_CYC  = (CFG_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CFG_CNT_W     = 8;
  localparam int unsigned CFG_WORDS     = 3;
  localparam int unsigned CFG_WORD_W    = 16;
  localparam int unsigned CFG_CMD_BITS  = 9;
  localparam int unsigned CFG_DATA_BITS = 17;
  localparam logic [2:0]  CFG_READ_OP   = 3'h6;
  localparam logic [15:0] CFG_BLANK     = 16'hffff;
  localparam int unsigned CFG_WAKE_WORD = 2;
  localparam int unsigned CFG_WAKE_BIT  = 8;
  localparam int unsigned FN_W          = 4;
  localparam int unsigned FN_PER_WORD   = 4;
  localparam int unsigned AUX_PINS      = 10;
  localparam int unsigned LOW_PINS      = 8;
  localparam int unsigned AUX_PD_PIN    = 7;
  localparam int unsigned PULLUP_KOHM   = 75;
  localparam logic [7:0]  LOW_OUT_MASK  = 8'h15;
  localparam int unsigned ADR_W         = 4;
  localparam logic [3:0]  ADDR_STATUS   = 4'h0;
  localparam logic [3:0]  ADDR_AUX_OUT  = 4'h4;
  localparam logic [3:0]  ADDR_AUX_IN   = 4'h8;
  localparam logic [3:0]  ADDR_LOW_IN   = 4'hc;
  localparam int unsigned ST_DONE_BIT   = 0;
  localparam int unsigned ST_PRES_BIT   = 1;
  localparam int unsigned ST_WAKE_BIT   = 2;
  localparam int unsigned ST_SUSP_BIT   = 3;
  localparam logic [9:0]  AUX_OUT_RST   = 10'h000;

  typedef enum logic [3:0] {
    FN_TRI_PU  = 4'h0,
    FN_TRI_PD  = 4'h1,
    FN_DRIVE0  = 4'h2,
    FN_DRIVE1  = 4'h3,
    FN_IO      = 4'h4,
    FN_TXDEN   = 4'h5,
    FN_SLEEP_N = 4'h6,
    FN_TXLED_N = 4'h7,
    FN_RXLED_N = 4'h8
  } aux_fn_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'h0,
    CS_CMD  = 3'h1,
    CS_DATA = 3'h2,
    CS_GAP  = 3'h3,
    CS_DONE = 3'h4
  } cfg_state_t;

  typedef struct packed {
    logic ri_n;
    logic dcd_n;
    logic dsr_n;
    logic cts_n;
    logic rxd;
  } modem_in_t;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
    logic txden;
    logic tx_active;
    logic rx_active;
  } uart_out_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
  } pad_ctl_t;
endpackage : io_pin_pkg

// file: cfgmem_reader.sv
// serial configuration memory reader, fetches a fixed block of words after reset
`timescale 1ns/1ps
module cfgmem_reader (
  input  wire logic                                     clk_i,
  input  wire logic                                     rst_i,
  input  wire logic                                     io_sync_i,
  output logic                                          sel_o,
  output logic                                          sclk_o,
  output logic                                          io_o,
  output logic                                          io_oe_o,
  output logic                                          done_o,
  output logic [io_pin_pkg::CFG_WORDS-1:0][io_pin_pkg::CFG_WORD_W-1:0] words_o
);
  io_pin_pkg::cfg_state_t                 state_q;
  logic [io_pin_pkg::CFG_CNT_W-1:0]       cnt_q;
  logic [4:0]                             bit_q;
  logic [1:0]                             word_q;
  logic [io_pin_pkg::CFG_CMD_BITS-1:0]    cmd_q;
  logic [io_pin_pkg::CFG_WORD_W-1:0]      sh_q;

  wire logic tick     = (cnt_q == io_pin_pkg::CFG_CNT_W'(io_pin_pkg::CFG_HALF_CYC - 1));
  wire logic rising   = tick & ~sclk_o;
  wire logic falling  = tick & sclk_o;
  wire logic last_cmd = (bit_q == 5'(io_pin_pkg::CFG_CMD_BITS - 1));
  wire logic last_dat = (bit_q == 5'(io_pin_pkg::CFG_DATA_BITS - 1));
  wire logic last_wd  = (word_q == 2'(io_pin_pkg::CFG_WORDS - 1));
  wire logic [io_pin_pkg::CFG_CMD_BITS-1:0] cmd_w = {io_pin_pkg::CFG_READ_OP, 4'h0, word_q};

  // one word per select frame keeps the sequencer small at the cost of extra command bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= io_pin_pkg::CS_IDLE;
      cnt_q   <= '0;
      bit_q   <= '0;
      word_q  <= '0;
      cmd_q   <= '0;
      sh_q    <= '0;
      sel_o   <= 1'b0;
      sclk_o  <= 1'b0;
      io_o    <= 1'b0;
      io_oe_o <= 1'b0;
      done_o  <= 1'b0;
      words_o <= '0;
    end else begin
      cnt_q <= (tick || state_q == io_pin_pkg::CS_IDLE) ? '0 : cnt_q + 1'b1;
      if (tick && (state_q == io_pin_pkg::CS_CMD || state_q == io_pin_pkg::CS_DATA)) begin
        sclk_o <= ~sclk_o;
      end
      unique case (state_q)
        io_pin_pkg::CS_IDLE: begin
          sel_o   <= 1'b1;
          io_oe_o <= 1'b1;
          io_o    <= cmd_w[io_pin_pkg::CFG_CMD_BITS-1];
          cmd_q   <= {cmd_w[io_pin_pkg::CFG_CMD_BITS-2:0], 1'b0};
          bit_q   <= '0;
          state_q <= io_pin_pkg::CS_CMD;
        end
        io_pin_pkg::CS_CMD: begin
          if (falling) begin
            bit_q <= last_cmd ? '0 : bit_q + 1'b1;
            io_o  <= last_cmd ? 1'b0 : cmd_q[io_pin_pkg::CFG_CMD_BITS-1];
            cmd_q <= {cmd_q[io_pin_pkg::CFG_CMD_BITS-2:0], 1'b0};
            if (last_cmd) begin
              io_oe_o <= 1'b0;
              state_q <= io_pin_pkg::CS_DATA;
            end
          end
        end
        io_pin_pkg::CS_DATA: begin
          if (rising) begin
            sh_q <= {sh_q[io_pin_pkg::CFG_WORD_W-2:0], io_sync_i};
          end
          if (falling) begin
            bit_q <= bit_q + 1'b1;
            if (last_dat) begin
              words_o[word_q] <= sh_q;
              sel_o           <= 1'b0;
              state_q         <= io_pin_pkg::CS_GAP;
            end
          end
        end
        io_pin_pkg::CS_GAP: begin
          if (tick) begin
            word_q  <= last_wd ? word_q : word_q + 1'b1;
            done_o  <= last_wd;
            state_q <= last_wd ? io_pin_pkg::CS_DONE : io_pin_pkg::CS_IDLE;
          end
        end
        io_pin_pkg::CS_DONE: begin
          sel_o <= 1'b0;
        end
        default: begin
          state_q <= io_pin_pkg::CS_IDLE;
        end
      endcase
    end
  end
endmodule : cfgmem_reader

// file: io_pin_default_config.sv
// mode independent pin control: reset pin, config memory pins, low and aux ports
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - external reset pin is active low
// - config memory pins float while in reset
// - config memory clock driven once out of reset
// - low port defaults to uart pin map
// - ring indicate low in suspend requests resume
// - aux pin function comes from config memory
// - blank memory: aux pins other than bit 7 input with pull-up
// - blank memory: aux bit 7 pulls down
// - pull-up pins use weak internal pull-up
module io_pin_default_config (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               ext_reset_n_i,
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [io_pin_pkg::ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [31:0]                        wb_dat_i,
  output logic      [31:0]                        wb_dat_o,
  output logic                                    wb_ack_o,
  input  wire logic                               cfgmem_select_i,
  output logic                                    cfgmem_select_o,
  output logic                                    cfgmem_select_oe_o,
  output logic                                    cfgmem_clock_o,
  output logic                                    cfgmem_clock_oe_o,
  input  wire logic                               cfgmem_io_i,
  output logic                                    cfgmem_io_o,
  output logic                                    cfgmem_io_oe_o,
  input  wire logic [io_pin_pkg::LOW_PINS-1:0]    low_port_i,
  output logic      [io_pin_pkg::LOW_PINS-1:0]    low_port_o,
  output logic      [io_pin_pkg::LOW_PINS-1:0]    low_port_oe_o,
  input  wire logic [io_pin_pkg::AUX_PINS-1:0]    aux_port_i,
  output logic      [io_pin_pkg::AUX_PINS-1:0]    aux_port_o,
  output logic      [io_pin_pkg::AUX_PINS-1:0]    aux_port_oe_o,
  output logic      [io_pin_pkg::AUX_PINS-1:0]    aux_port_pu_o,
  output logic      [io_pin_pkg::AUX_PINS-1:0]    aux_port_pd_o,
  input  wire io_pin_pkg::uart_out_t              uart_i,
  output io_pin_pkg::modem_in_t                   modem_o,
  input  wire logic                               suspend_i,
  output logic                                    resume_o,
  output logic                                    cfg_done_o
);
  logic [1:0]                          rst_pin_q;
  logic [io_pin_pkg::LOW_PINS-1:0]     low_s1_q;
  logic [io_pin_pkg::LOW_PINS-1:0]     low_s2_q;
  logic [io_pin_pkg::AUX_PINS-1:0]     aux_s1_q;
  logic [io_pin_pkg::AUX_PINS-1:0]     aux_s2_q;
  logic [1:0]                          cio_q;
  logic [io_pin_pkg::AUX_PINS-1:0]     aux_out_q;
  logic                                wake_cond_q;
  logic                                rd_sel;
  logic                                rd_clk;
  logic                                rd_io;
  logic                                rd_io_oe;
  logic                                rd_done;
  logic [io_pin_pkg::CFG_WORDS-1:0][io_pin_pkg::CFG_WORD_W-1:0] rd_words;

  // the pin is sampled twice before use; a glitch shorter than a clock may be missed
  wire logic core_rst = rst_i | ~rst_pin_q[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pin_q <= 2'h0;
    end else begin
      rst_pin_q <= {rst_pin_q[0], ext_reset_n_i};
    end
  end

  always_ff @(posedge clk_i) begin
    low_s1_q <= low_port_i;
    low_s2_q <= low_s1_q;
    aux_s1_q <= aux_port_i;
    aux_s2_q <= aux_s1_q;
    cio_q    <= {cio_q[0], cfgmem_io_i};
  end

  cfgmem_reader u_reader (
    .clk_i     (clk_i),
    .rst_i     (core_rst),
    .io_sync_i (cio_q[1]),
    .sel_o     (rd_sel),
    .sclk_o    (rd_clk),
    .io_o      (rd_io),
    .io_oe_o   (rd_io_oe),
    .done_o    (rd_done),
    .words_o   (rd_words)
  );

  // an erased or missing memory reads as all ones through its data pull-up
  wire logic cfg_present = rd_done & (rd_words[0] != io_pin_pkg::CFG_BLANK);
  wire logic wake_en     = cfg_present &
                           rd_words[io_pin_pkg::CFG_WAKE_WORD][io_pin_pkg::CFG_WAKE_BIT];
  wire logic wake_cond   = wake_en & suspend_i & ~low_s2_q[7];

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      cfgmem_select_o    <= 1'b0;
      cfgmem_select_oe_o <= 1'b0;
      cfgmem_clock_o     <= 1'b0;
      cfgmem_clock_oe_o  <= 1'b0;
      cfgmem_io_o        <= 1'b0;
      cfgmem_io_oe_o     <= 1'b0;
      cfg_done_o         <= 1'b0;
      wake_cond_q        <= 1'b0;
      resume_o           <= 1'b0;
    end else begin
      cfgmem_select_o    <= rd_sel;
      cfgmem_select_oe_o <= 1'b1;
      cfgmem_clock_o     <= rd_clk;
      cfgmem_clock_oe_o  <= 1'b1;
      cfgmem_io_o        <= rd_io;
      cfgmem_io_oe_o     <= rd_io_oe;
      cfg_done_o         <= rd_done;
      wake_cond_q        <= wake_cond;
      resume_o           <= wake_cond & ~wake_cond_q;
    end
  end

  // low port: fixed uart map, outputs on bits 0, 2 and 4
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      low_port_o    <= '0;
      low_port_oe_o <= '0;
      modem_o       <= '1;
    end else begin
      low_port_o    <= {3'h0, uart_i.dtr_n, 1'b0, uart_i.rts_n, 1'b0, uart_i.txd};
      low_port_oe_o <= io_pin_pkg::LOW_OUT_MASK;
      modem_o       <= {low_s2_q[7:5], low_s2_q[3], low_s2_q[1]};
    end
  end

  // aux port: per pin function, default pulls until the memory has been read
  genvar i;
  generate
    for (i = 0; i < io_pin_pkg::AUX_PINS; i++) begin : g_aux
      localparam int unsigned WD = i / io_pin_pkg::FN_PER_WORD;
      localparam int unsigned NB = (i % io_pin_pkg::FN_PER_WORD) * io_pin_pkg::FN_W;
      localparam logic        PD_PIN = (i == io_pin_pkg::AUX_PD_PIN);
      wire logic [3:0] fn_raw = rd_words[WD][NB +: io_pin_pkg::FN_W];
      wire logic [3:0] dflt   = PD_PIN ? 4'(io_pin_pkg::FN_TRI_PD)
                                       : 4'(io_pin_pkg::FN_TRI_PU);
      wire logic [3:0] fn     = cfg_present ? fn_raw : dflt;
      io_pin_pkg::pad_ctl_t pad;
      always_comb begin
        pad = '{out: 1'b0, oe: 1'b1, pu: 1'b0, pd: 1'b0};
        case (fn)
          io_pin_pkg::FN_TRI_PD:  pad = '{out: 1'b0, oe: 1'b0, pu: 1'b0, pd: 1'b1};
          io_pin_pkg::FN_DRIVE0:  pad.out = 1'b0;
          io_pin_pkg::FN_DRIVE1:  pad.out = 1'b1;
          io_pin_pkg::FN_IO:      pad.out = aux_out_q[i];
          io_pin_pkg::FN_TXDEN:   pad.out = uart_i.txden;
          io_pin_pkg::FN_SLEEP_N: pad.out = ~suspend_i;
          io_pin_pkg::FN_TXLED_N: pad.out = ~uart_i.tx_active;
          io_pin_pkg::FN_RXLED_N: pad.out = ~uart_i.rx_active;
          // unknown codes fall back to the safe weak pull-up input
          default: pad = '{out: 1'b0, oe: 1'b0, pu: 1'b1, pd: 1'b0};
        endcase
      end
      always_ff @(posedge clk_i) begin
        if (core_rst) begin
          aux_port_o[i]    <= 1'b0;
          aux_port_oe_o[i] <= 1'b0;
          aux_port_pu_o[i] <= ~PD_PIN;
          aux_port_pd_o[i] <= PD_PIN;
        end else begin
          aux_port_o[i]    <= pad.out;
          aux_port_oe_o[i] <= pad.oe;
          aux_port_pu_o[i] <= pad.pu;
          aux_port_pd_o[i] <= pad.pd;
        end
      end
    end
  endgenerate

  // wishbone slave, one wait state, unmapped reads return zero
  wire logic wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic hit_out = (wb_adr_i == io_pin_pkg::ADDR_AUX_OUT);
  wire logic [31:0] status_w = {28'h0, suspend_i, wake_en, cfg_present, rd_done};
  wire logic [31:0] rd_mux =
      (wb_adr_i == io_pin_pkg::ADDR_STATUS) ? status_w :
      hit_out                               ? {22'h0, aux_out_q} :
      (wb_adr_i == io_pin_pkg::ADDR_AUX_IN) ? {22'h0, aux_s2_q} :
      (wb_adr_i == io_pin_pkg::ADDR_LOW_IN) ? {24'h0, low_s2_q} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= '0;
      aux_out_q <= io_pin_pkg::AUX_OUT_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we_i) ? rd_mux : 32'h0;
      if (wb_req && wb_we_i && hit_out && wb_sel_i[0]) begin
        aux_out_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_req && wb_we_i && hit_out && wb_sel_i[1]) begin
        aux_out_q[9:8] <= wb_dat_i[9:8];
      end
    end
  end
endmodule : io_pin_default_config

// file: io_pin_sva.sv
// assertions on the ports of the pin default block
`timescale 1ns/1ps
module io_pin_sva (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ext_reset_n_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  cfgmem_select_oe_o,
  input wire logic                  cfgmem_clock_oe_o,
  input wire logic                  cfgmem_io_oe_o,
  input wire logic [7:0]            low_port_i,
  input wire logic [7:0]            low_port_o,
  input wire logic [7:0]            low_port_oe_o,
  input wire logic [9:0]            aux_port_oe_o,
  input wire logic [9:0]            aux_port_pu_o,
  input wire logic [9:0]            aux_port_pd_o,
  input wire io_pin_pkg::uart_out_t uart_i,
  input wire io_pin_pkg::modem_in_t modem_o,
  input wire logic                  suspend_i,
  input wire logic                  resume_o,
  input wire logic                  cfg_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire mem_off = !cfgmem_select_oe_o && !cfgmem_clock_oe_o && !cfgmem_io_oe_o;
  wire ri_n    = low_port_i[7];
  // the reset itself is the cause here, so this one is never disabled
  a_mem_float_rst: assert property (disable iff (1'b0) rst_i |=> mem_off)
    else $error("config pins driven in reset");
  a_pin_rst_low: assert property (!ext_reset_n_i [*3] |=> mem_off && !cfg_done_o)
    else $error("reset pin ignored");
  a_mem_clk_drive: assert property (
    (ext_reset_n_i && !rst_i) [*8] |-> cfgmem_clock_oe_o)
    else $error("config clock not driven");
  a_low_dir_map: assert property (
    cfg_done_o |-> low_port_oe_o == io_pin_pkg::LOW_OUT_MASK)
    else $error("low port direction wrong");
  a_low_out_map: assert property (
    cfg_done_o && $past(cfg_done_o) |-> low_port_o == {3'h0, $past(uart_i.dtr_n),
    1'b0, $past(uart_i.rts_n), 1'b0, $past(uart_i.txd)})
    else $error("low port outputs misrouted");
  a_modem_map: assert property (
    (cfg_done_o && $stable(low_port_i)) [*4] |->
    modem_o == {low_port_i[7:5], low_port_i[3], low_port_i[1]})
    else $error("modem inputs misrouted");
  a_resume_cause: assert property (
    $rose(resume_o) |-> cfg_done_o && $past(suspend_i) && !$past(ri_n, 3))
    else $error("resume without cause");
  a_resume_pulse: assert property (resume_o |=> !resume_o)
    else $error("resume longer than one cycle");
  a_aux_default: assert property (
    !cfg_done_o |-> aux_port_oe_o == 10'h000 && aux_port_pu_o == 10'h37f &&
    aux_port_pd_o == 10'h080)
    else $error("aux defaults lost before load");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acked");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  c_load_done: cover property ($rose(cfg_done_o));
  c_resume: cover property ($rose(resume_o));
  c_bus_access: cover property (wb_cyc_i && wb_ack_o);
endmodule : io_pin_sva

// file: cfgmem_model.sv
// behavioural serial configuration memory, data line pulled up when released
`timescale 1ns/1ps
module cfgmem_model (
  input  wire logic        sel_i,
  input  wire logic        sclk_i,
  input  wire logic        io_i,
  input  wire logic        fitted_i,
  input  wire logic [47:0] words_i,
  output logic             io_o,
  output logic             io_oe_o
);
  int          cnt = 0;
  logic [8:0]  cmd;
  logic [16:0] sh;
  initial begin
    io_oe_o = 1'b0;
    io_o = 1'b0;
  end
  // deselect aborts a frame and frees the line
  always @(negedge sel_i) begin
    cnt = 0;
    io_oe_o = 1'b0;
  end
  always @(posedge sclk_i) begin
    if (sel_i && fitted_i) begin
      if (cnt < 9) cmd = {cmd[7:0], io_i};
      cnt++;
      // a malformed command gets no answer at all
      if (cnt == 9 && cmd[8:6] == io_pin_pkg::CFG_READ_OP && cmd[5:0] < 6'h3)
        sh = {1'b0, words_i[cmd[1:0]*16 +: 16]};
      else if (cnt == 9) cnt = 99;
    end
  end
  always @(negedge sclk_i) begin
    io_oe_o = sel_i && fitted_i && cnt >= 9 && cnt < 26;
    io_o = io_oe_o ? sh[16] : ~io_o;
    sh = sh << 1;
  end
endmodule : cfgmem_model

// file: tb.sv
// testbench for pin defaults, config load, uart map, resume and registers
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  localparam logic [47:0] WORDS = 48'h0104_8765_4123;
  logic clk_i, rst_i, ext_reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic cfgmem_select_i, cfgmem_select_o, cfgmem_select_oe_o, cfgmem_clock_o;
  logic cfgmem_clock_oe_o, cfgmem_io_i, cfgmem_io_o, cfgmem_io_oe_o;
  logic suspend_i, resume_o, cfg_done_o, fitted, mem_io, mem_oe;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, r;
  logic [7:0]  low_port_i, low_port_o, low_port_oe_o;
  logic [9:0]  aux_port_i, aux_port_o, aux_port_oe_o, aux_port_pu_o, aux_port_pd_o;
  io_pin_pkg::uart_out_t uart_i;
  io_pin_pkg::modem_in_t modem_o;
  logic [31:0] seed = 32'h4e552e4d;
  int          err_total = 0;
  int          comparisons = 0;
  assign cfgmem_io_i = cfgmem_io_oe_o ? cfgmem_io_o : (mem_oe ? mem_io : 1'b1);
  assign cfgmem_select_i = cfgmem_select_oe_o & cfgmem_select_o;
  io_pin_default_config u_io_pin_default_config (.*);
  cfgmem_model u_cfgmem_model (
    .sel_i   (cfgmem_select_i),
    .sclk_i  (cfgmem_clock_oe_o & cfgmem_clock_o),
    .io_i    (cfgmem_io_i),
    .fitted_i(fitted),
    .words_i (WORDS),
    .io_o    (mem_io),
    .io_oe_o (mem_oe)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected {out, oe, pu, pd} of one aux pin
  function automatic io_pin_pkg::pad_ctl_t exp_pad(input int i, input bit fit);
    logic [3:0] f;
    f = fit ? WORDS[i*4 +: 4] : ((i == 7) ? 4'h1 : 4'h0);
    case (f)
      io_pin_pkg::FN_TRI_PD:  exp_pad = 4'b0001;
      io_pin_pkg::FN_DRIVE0:  exp_pad = 4'b0100;
      io_pin_pkg::FN_DRIVE1:  exp_pad = 4'b1100;
      io_pin_pkg::FN_IO:      exp_pad = {r[i], 3'b100};
      io_pin_pkg::FN_TXDEN:   exp_pad = {uart_i.txden, 3'b100};
      io_pin_pkg::FN_SLEEP_N: exp_pad = {~suspend_i, 3'b100};
      io_pin_pkg::FN_TXLED_N: exp_pad = {~uart_i.tx_active, 3'b100};
      io_pin_pkg::FN_RXLED_N: exp_pad = {~uart_i.rx_active, 3'b100};
      default:                exp_pad = 4'b0010;
    endcase
  endfunction : exp_pad
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'h3};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) err_total++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic run(input bit fit);
    io_pin_pkg::pad_ctl_t p;
    logic [2:0] pc;
    int n;
    suspend_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    `CHK({cfgmem_clock_oe_o, cfg_done_o}, 2'b10)
    n = 0;
    while (cfg_done_o !== 1'b1 && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(cfg_done_o, 1'b1)
    wb(1'b1, io_pin_pkg::ADDR_STATUS, 32'hffffffff);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, io_pin_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, fit ? 32'h7 : 32'h1)
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h0 : rnd();
      wb(1'b1, io_pin_pkg::ADDR_AUX_OUT, r);
      wb(1'b0, io_pin_pkg::ADDR_AUX_OUT, 32'h0);
      `CHK(rd, {22'h0, r[9:0]})
      {uart_i, aux_port_i, suspend_i} <= r[31:15];
      low_port_i <= r[17:10] | 8'h80;
      repeat (5) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
        p = exp_pad(i, fit);
        pc = {aux_port_oe_o[i], aux_port_pu_o[i], aux_port_pd_o[i]};
        `CHK(pc, p[2:0])
        if (p.oe) `CHK(aux_port_o[i], p.out)
      end
      `CHK(low_port_oe_o, io_pin_pkg::LOW_OUT_MASK)
      `CHK(low_port_o, {3'h0, uart_i.dtr_n, 1'b0, uart_i.rts_n, 1'b0, uart_i.txd})
      `CHK(modem_o, {low_port_i[7:5], low_port_i[3], low_port_i[1]})
      wb(1'b0, io_pin_pkg::ADDR_LOW_IN, 32'h0);
      `CHK(rd, {24'h0, low_port_i})
      wb(1'b0, io_pin_pkg::ADDR_AUX_IN, 32'h0);
      `CHK(rd, {22'h0, aux_port_i})
    end
    suspend_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    low_port_i[7] <= 1'b0;
    n = 0;
    repeat (10) begin
      @(posedge clk_i);
      if (resume_o === 1'b1) n++;
    end
    `CHK(n, fit ? 1 : 0)
    low_port_i[7] <= 1'b1;
  endtask : run
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    {rst_i, ext_reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, suspend_i, fitted} = 7'h60;
    {wb_adr_i, wb_sel_i, wb_dat_i, aux_port_i, uart_i, r} = '0;
    low_port_i = 8'hff;
    repeat (12) @(posedge clk_i);
    `CHK({cfgmem_select_oe_o, cfgmem_clock_oe_o, cfgmem_io_oe_o}, 3'h0)
    rst_i <= 1'b0;
    run(1'b0);
    fitted <= 1'b1;
    ext_reset_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK({cfgmem_select_oe_o, cfgmem_clock_oe_o, cfgmem_io_oe_o}, 3'h0)
    `CHK(cfg_done_o, 1'b0)
    ext_reset_n_i <= 1'b1;
    run(1'b1);
    print_verdict();
  end
  initial begin
    #300000;
    err_total++;
    print_verdict();
  end
endmodule : tb
bind io_pin_default_config io_pin_sva u_io_pin_sva (.*);
